// [verilog/srps_top.sv]
`timescale 1ns/10ps
module srps_top
    import srps_pkg::*;
#(
    parameter int DPW = DP_WIDTH,
    parameter int CW  = CNTL_WIDTH
) (
    // system clock, reset, enable
    input  wire logic           clk_sys,
    input  wire logic           reset,
    input  wire logic           clk_en,
    // static control pins
    input  wire logic           role_select,
    input  wire logic           chip_clear_n,
    input  wire logic           standby_n,
    input  wire logic           edge_rate_select,
    input  wire logic           display_iface_select,
    input  wire logic           strobe_source_select,
    // parallel pins
    input  wire logic [DPW-1:0] parallel_data_bus_in,
    output logic      [DPW-1:0] parallel_data_bus_out,
    output logic      [DPW-1:0] parallel_data_bus_oe,
    input  wire logic [CW-1:0]  control_bus_in,
    output logic      [CW-1:0]  control_bus_out,
    output logic      [CW-1:0]  control_bus_oe,
    input  wire logic           read_write_in,
    output logic                read_write_out,
    output logic                read_write_oe,
    input  wire logic           input_strobe0,
    input  wire logic           input_strobe1,
    output logic                output_word_clock0,
    output logic                output_word_clock1,
    // core side, system domain
    input  wire logic [DPW-1:0] core_dp_out,
    input  wire logic [CW-1:0]  core_cntl_out,
    input  wire logic           core_rw_state,
    input  wire logic [1:0]     core_word_clock,
    input  wire logic           core_spi_clk,
    input  wire logic           core_spi_data,
    input  wire logic           core_spi_cs_n,
    output logic      [DPW-1:0] rx_dp,
    output logic      [CW-1:0]  rx_cntl,
    output logic                rx_rw,
    output logic                rx_spi_cs_n,
    output logic                active_strobe,
    output logic                is_master,
    output logic                device_enable,
    output logic                fast_edges,
    // link side, link clock domain
    input  wire logic           clk_link,
    input  wire logic           core_link_standby,
    input  wire logic           core_link_drive,
    input  wire logic           core_link_clk,
    input  wire logic           core_link_data,
    output logic                rx_link_clk,
    output logic                rx_link_data,
    input  wire logic [3:0]     link_pad_in,
    output logic      [3:0]     link_pad_out,
    output logic      [3:0]     link_pad_oe
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [7:0]        ctl_s;
    logic [DPW+CW:0]   bus_s;
    logic              clear_s;
    logic              standby_s;
    logic              edge_s;
    logic              input_strobe0_s;
    logic              input_strobe1_s;
    logic [DPW-1:0]    dp_s;
    logic [CW-1:0]     cntl_s;
    logic              rw_s;
    logic              link_standby_n_s;
    logic              link_standby_req;

    srps_sync #(.WIDTH(8)) u_sync_ctl (
        .clk    (clk_sys),
        .reset  (reset),
        .clk_en (clk_en),
        .d      ({role_select, chip_clear_n, standby_n, edge_rate_select,
                  display_iface_select, strobe_source_select,
                  input_strobe1, input_strobe0}),
        .q      (ctl_s)
    );

    srps_sync #(.WIDTH(DPW+CW+1)) u_sync_bus (
        .clk    (clk_sys),
        .reset  (reset),
        .clk_en (clk_en),
        .d      ({read_write_in, control_bus_in, parallel_data_bus_in}),
        .q      (bus_s)
    );

    srps_sync #(.WIDTH(1)) u_sync_standby_n (
        .clk    (clk_sys),
        .reset  (reset),
        .clk_en (clk_en),
        .d      (link_standby_req),
        .q      (link_standby_n_s)
    );

    assign clear_s   = ctl_s[6];
    assign standby_s = ctl_s[5];
    assign edge_s    = ctl_s[4];
    assign input_strobe1_s   = ctl_s[1];
    assign input_strobe0_s   = ctl_s[0];
    assign dp_s      = bus_s[DPW-1:0];
    assign cntl_s    = bus_s[DPW+CW-1:DPW];
    assign rw_s      = bus_s[DPW+CW];

    // ************************************************************
    // configuration, captured only while held in clear
    // ************************************************************
    logic cfg_master;
    logic cfg_parallel;
    logic cfg_src_one;

    // later changes are ignored so a glitching strap cannot flip roles mid-frame
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cfg_master   <= 1'b0;
            cfg_parallel <= IFACE_PARALLEL;
            cfg_src_one  <= 1'b0;
        end else if (clk_en && !clear_s) begin
            cfg_master   <= (ctl_s[7] == ROLE_MASTER);
            cfg_parallel <= (ctl_s[3] == IFACE_PARALLEL);
            cfg_src_one  <= (ctl_s[2] == STROBE_SRC_ONE);
        end
    end

    // ************************************************************
    // power mode
    // ************************************************************
    srps_mode_t mode;
    srps_mode_t next_mode;
    logic       spi_mode;

    assign spi_mode = !cfg_parallel;

    always_comb begin
        if (!clear_s) begin
            next_mode = SRPS_RESET;
        end else if (cfg_master) begin
            next_mode = standby_s ? SRPS_OPERATE : SRPS_STANDBY;
        end else begin
            next_mode = link_standby_n_s ? SRPS_STANDBY : SRPS_OPERATE;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mode <= SRPS_RESET;
        end else if (clk_en) begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            device_enable <= 1'b0;
            is_master     <= 1'b0;
            fast_edges    <= 1'b0;
        end else if (clk_en) begin
            device_enable <= (mode == SRPS_OPERATE);
            is_master     <= cfg_master;
            fast_edges    <= !cfg_master && (edge_s == EDGE_FAST);
        end
    end

    // ************************************************************
    // pin direction and sharing
    // ************************************************************
    logic           read_now;
    logic [DPW-1:0] next_dp_out;
    logic [DPW-1:0] next_dp_oe;
    logic [CW-1:0]  next_cntl_out;

    // SPI never reads, so the bus stays pointed at the display
    assign read_now = (core_rw_state == RW_READ) && !spi_mode;

    always_comb begin
        next_dp_out   = core_dp_out;
        next_cntl_out = core_cntl_out;
        if (cfg_master) begin
            next_dp_oe = (mode == SRPS_OPERATE && read_now) ? '1 : '0;
        end else begin
            next_dp_oe = read_now ? '0 : '1;
        end
        if (!cfg_master && spi_mode) begin
            next_dp_oe[DP_SPI_CLK_BIT]      = 1'b1;
            next_dp_oe[DP_SPI_DAT_BIT]      = 1'b1;
            next_dp_out[DP_SPI_CLK_BIT]     = core_spi_clk;
            next_dp_out[DP_SPI_DAT_BIT]     = core_spi_data;
            next_cntl_out[CNTL_SPI_CLK_BIT] = core_spi_clk;
            next_cntl_out[CNTL_SPI_DAT_BIT] = core_spi_data;
        end
    end

    // slave holds last data in standby; master floats outside operation
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            parallel_data_bus_out <= '0;
            parallel_data_bus_oe  <= '0;
            control_bus_out       <= '0;
            control_bus_oe        <= '0;
            read_write_out        <= RW_WRITE;
            read_write_oe         <= 1'b0;
        end else if (clk_en) begin
            if (cfg_master) begin
                parallel_data_bus_out <= next_dp_out;
                parallel_data_bus_oe  <= next_dp_oe;
                control_bus_oe        <= '0;
                read_write_oe         <= 1'b0;
            end else if (mode == SRPS_RESET) begin
                parallel_data_bus_out <= {DPW{OUT_RESET_LEVEL}};
                parallel_data_bus_oe  <= '1;
                control_bus_out       <= {CW{OUT_RESET_LEVEL}};
                control_bus_oe        <= '1;
                read_write_out        <= OUT_RESET_LEVEL;
                read_write_oe         <= 1'b1;
            end else if (mode == SRPS_OPERATE) begin
                parallel_data_bus_out <= next_dp_out;
                parallel_data_bus_oe  <= next_dp_oe;
                control_bus_out       <= next_cntl_out;
                control_bus_oe        <= '1;
                read_write_out        <= spi_mode ? RW_WRITE : core_rw_state;
                read_write_oe         <= 1'b1;
            end
        end
    end

    // ************************************************************
    // strobes and word clocks
    // ************************************************************
    logic next_strobe;

    always_comb begin
        if (cfg_src_one) begin
            next_strobe = input_strobe1_s;
        end else if (spi_mode) begin
            next_strobe = cntl_s[CNTL_SPI_CLK_BIT];
        end else begin
            next_strobe = input_strobe0_s;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            active_strobe      <= 1'b0;
            output_word_clock0 <= WCLK_IDLE;
            output_word_clock1 <= WCLK_IDLE;
        end else if (clk_en) begin
            active_strobe <= cfg_master && (mode == SRPS_OPERATE) && next_strobe;
            if (cfg_master || mode != SRPS_OPERATE) begin
                output_word_clock0 <= WCLK_IDLE;
                output_word_clock1 <= WCLK_IDLE;
            end else begin
                if (spi_mode) begin
                    output_word_clock0 <= core_spi_cs_n;
                end else begin
                    output_word_clock0 <= cfg_src_one ? WCLK_IDLE : core_word_clock[0];
                end
                output_word_clock1 <= cfg_src_one ? core_word_clock[1] : WCLK_IDLE;
            end
        end
    end

    // host SPI arrives on shared pins when a master runs in SPI mode
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rx_dp       <= '0;
            rx_cntl     <= '0;
            rx_rw       <= RW_WRITE;
            rx_spi_cs_n <= 1'b1;
        end else if (clk_en) begin
            rx_dp       <= dp_s;
            rx_cntl     <= cntl_s;
            rx_rw       <= spi_mode ? RW_WRITE : rw_s;
            rx_spi_cs_n <= (cfg_master && spi_mode) ? input_strobe0_s : 1'b1;
        end
    end

    // ************************************************************
    // link domain: pad orientation
    // ************************************************************
    logic       link_req;
    logic       link_standby_n_req;
    logic [2:0] link_s;
    logic       link_master;
    logic       link_drive_ok;
    logic       link_en;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            link_req <= 1'b0;
        end else if (clk_en) begin
            link_req <= (mode == SRPS_OPERATE);
        end
    end

    srps_sync #(.WIDTH(3)) u_sync_link (
        .clk    (clk_link),
        .reset  (reset),
        .clk_en (1'b1),
        .d      ({clk_en, cfg_master, link_req}),
        .q      (link_s)
    );

    assign link_en       = link_s[2];
    assign link_master   = link_s[1];
    assign link_drive_ok = link_s[0];

    always_ff @(posedge clk_link or posedge reset) begin
        if (reset) begin
            link_standby_n_req <= 1'b0;
        end else if (link_en) begin
            link_standby_n_req <= core_link_standby && !link_master;
        end
    end
    assign link_standby_req = link_standby_n_req;

    function automatic logic [3:0] srps_place(input logic master, input logic [3:0] v);
        srps_place = master ? v : {v[0], v[1], v[2], v[3]};
    endfunction

    logic [3:0] pad_order;
    logic [3:0] pad_in_order;
    logic       drive;

    assign drive        = core_link_drive && link_drive_ok;
    assign pad_order    = {core_link_data, !core_link_data, !core_link_clk, core_link_clk};
    assign pad_in_order = srps_place(link_master, link_pad_in);

    always_ff @(posedge clk_link or posedge reset) begin
        if (reset) begin
            link_pad_out <= '0;
            link_pad_oe  <= '0;
            rx_link_clk  <= 1'b0;
            rx_link_data <= 1'b0;
        end else if (link_en) begin
            link_pad_out <= srps_place(link_master, pad_order);
            link_pad_oe  <= drive ? 4'hf : 4'h0;
            rx_link_clk  <= pad_in_order[PAD_CLK_POS];
            rx_link_data <= pad_in_order[PAD_DAT_POS];
        end
    end

    generate
        if (DPW <= DP_SPI_DAT_BIT || CW <= CNTL_SPI_CLK_BIT) begin : g_bad
            $error("srps_top: buses too narrow for SPI sharing");
        end
    endgenerate

    // ************************************************************
    // checks
    // ************************************************************
    sequence seq_clear_held;
        clk_en && !clear_s ##1 clk_en;
    endsequence

    sequence seq_slave_spi_run;
        clk_en && !cfg_master && spi_mode && mode == SRPS_OPERATE;
    endsequence

    chk_clear_powers_down: assert property (@(posedge clk_sys) disable iff (reset)
        seq_clear_held |=> !device_enable)
        else $error("enable seen while clear held");
    chk_master_standby: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && cfg_master && clear_s && !standby_s |=> mode == SRPS_STANDBY)
        else $error("master ignored standby pin");
    chk_slave_no_pin: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && !cfg_master && clear_s && !link_standby_n_s |=> mode == SRPS_OPERATE)
        else $error("slave left operation without link command");
    chk_master_cntl_in: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && cfg_master |=> control_bus_oe == '0 && !read_write_oe)
        else $error("master drives control or read/write");
    chk_slave_rw_out: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && !cfg_master && mode == SRPS_OPERATE |=> read_write_oe
            && read_write_out == ($past(spi_mode) ? RW_WRITE : $past(core_rw_state)))
        else $error("slave read/write not driven");
    chk_edge_rate: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en |=> fast_edges == (!$past(cfg_master) && $past(edge_s)))
        else $error("edge rate mismatch");
    chk_spi_clk_share: assert property (@(posedge clk_sys) disable iff (reset)
        seq_slave_spi_run |=> parallel_data_bus_oe[DP_SPI_CLK_BIT]
            && parallel_data_bus_out[DP_SPI_CLK_BIT] == $past(core_spi_clk)
            && control_bus_out[CNTL_SPI_CLK_BIT] == $past(core_spi_clk)
            && parallel_data_bus_out[DP_SPI_DAT_BIT] == $past(core_spi_data))
        else $error("spi pins not shared");
    chk_spi_cs_wclk: assert property (@(posedge clk_sys) disable iff (reset)
        seq_slave_spi_run |=> output_word_clock0 == $past(core_spi_cs_n))
        else $error("chip select not on word clock 0");
    chk_strobe_pick: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && cfg_master && mode == SRPS_OPERATE && !spi_mode |=> active_strobe
            == ($past(cfg_src_one) ? $past(input_strobe1_s) : $past(input_strobe0_s)))
        else $error("wrong strobe selected");
    chk_spi_write_only: assert property (@(posedge clk_sys) disable iff (reset)
        clk_en && spi_mode |=> rx_rw == RW_WRITE)
        else $error("read passed in spi mode");
    chk_pad_mirror: assert property (@(posedge clk_link) disable iff (reset)
        link_en && !link_master |=> link_pad_out[0] == $past(core_link_data))
        else $error("slave pads not mirrored");

endmodule

// [verilog/srps_pkg.sv]
package srps_pkg;

    // ************************************************************
    // widths and shared bit positions
    // ************************************************************
    localparam int DP_WIDTH          = 18;
    localparam int CNTL_WIDTH        = 6;
    localparam int SYNC_STAGES       = 2;
    localparam int DP_SPI_CLK_BIT    = 6;
    localparam int DP_SPI_DAT_BIT    = 7;
    localparam int CNTL_SPI_CLK_BIT  = 5;
    localparam int CNTL_SPI_DAT_BIT  = 4;

    // ************************************************************
    // pin levels and encodings
    // ************************************************************
    localparam logic ROLE_MASTER     = 1'b1;
    localparam logic IFACE_PARALLEL  = 1'b1;
    localparam logic STROBE_SRC_ONE  = 1'b1;
    localparam logic RW_READ         = 1'b1;
    localparam logic RW_WRITE        = 1'b0;
    localparam logic EDGE_FAST       = 1'b1;
    localparam logic WCLK_IDLE       = 1'b1;
    localparam logic OUT_RESET_LEVEL = 1'b0;

    // ************************************************************
    // serial pad positions (master order; slave mirrors them)
    // ************************************************************
    localparam int PAD_COUNT         = 4;
    localparam int PAD_CLK_POS       = 0;
    localparam int PAD_CLK_NEG       = 1;
    localparam int PAD_DAT_NEG       = 2;
    localparam int PAD_DAT_POS       = 3;

    typedef enum logic [1:0] {
        SRPS_RESET,
        SRPS_STANDBY,
        SRPS_OPERATE
    } srps_mode_t;

endpackage

// [verilog/srps_sync.sv]
`timescale 1ns/10ps
module srps_sync
    import srps_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    // data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    // first stage is read by the second stage only
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1 <= '0;
            q      <= '0;
        end else if (clk_en) begin
            stage1 <= d;
            q      <= stage1;
        end
    end

    generate
        if (WIDTH < 1 || SYNC_STAGES != 2) begin : g_bad
            $error("srps_sync: unsupported width or depth");
        end
    endgenerate

endmodule

// [bench/srps_far_end.sv]
`timescale 1ns/10ps
module srps_far_end
    import srps_pkg::*;
(
    // clock and who drives
    input  wire logic        clk_sys,
    input  wire logic        host_on,
    // host requests
    input  wire logic [5:0]  host_cntl,
    input  wire logic        host_rw,
    // device side of the pins
    input  wire logic [17:0] dp_out,
    input  wire logic [17:0] dp_oe,
    input  wire logic [5:0]  cntl_out,
    input  wire logic [5:0]  cntl_oe,
    input  wire logic        rw_out,
    input  wire logic        rw_oe,
    // resolved pin levels
    output logic      [17:0] dp_in,
    output logic      [5:0]  cntl_in,
    output logic             rw_in
);
    logic flip = 1'b0;
    // released lines wander so a stale level never passes
    always_ff @(posedge clk_sys) begin
        flip <= ~flip;
    end
    assign dp_in = (dp_oe & dp_out) | (~dp_oe & {18{flip}});
    // host puts spi clock on bit 5 and data on bit 4
    assign cntl_in = (cntl_oe & cntl_out)
        | (~cntl_oe & (host_on ? host_cntl : {6{flip}}));
    assign rw_in = rw_oe ? rw_out : (host_on ? host_rw : flip);
endmodule

// [bench/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    import srps_pkg::*;
    logic clk_sys = 1'b0, clk_link = 1'b0, reset = 1'b1, clk_en = 1'b1;
    logic role_select = 1'b1, chip_clear_n = 1'b0, standby_n = 1'b1;
    logic edge_rate_select = 1'b0, display_iface_select = 1'b1, strobe_source_select = 1'b0;
    logic input_strobe0 = 1'b0, input_strobe1 = 1'b0, core_rw_state = 1'b0;
    logic core_spi_clk = 1'b0, core_spi_data = 1'b0, core_spi_cs_n = 1'b1;
    logic core_link_standby = 1'b0, core_link_drive = 1'b0;
    logic core_link_clk = 1'b0, core_link_data = 1'b0, host_rw = 1'b0;
    logic [5:0]  host_cntl = 6'h00, core_cntl_out = 6'h00;
    logic [17:0] core_dp_out = 18'h00000;
    logic [1:0]  core_word_clock = 2'h3;
    logic [3:0]  link_pad_in = 4'h0;
    wire  [17:0] parallel_data_bus_in, parallel_data_bus_out, parallel_data_bus_oe, rx_dp;
    wire  [5:0]  control_bus_in, control_bus_out, control_bus_oe, rx_cntl;
    wire  [3:0]  link_pad_out, link_pad_oe;
    wire read_write_in, read_write_out, read_write_oe, output_word_clock0, output_word_clock1;
    wire rx_rw, rx_spi_cs_n, active_strobe, is_master, device_enable, fast_edges;
    wire rx_link_clk, rx_link_data;
    int n_mismatch = 0;
    int compares = 0;

    srps_top i_dut (.*);
    srps_far_end i_far (.clk_sys(clk_sys), .host_on(role_select), .host_cntl(host_cntl),
        .host_rw(host_rw), .dp_out(parallel_data_bus_out), .dp_oe(parallel_data_bus_oe),
        .cntl_out(control_bus_out), .cntl_oe(control_bus_oe), .rw_out(read_write_out),
        .rw_oe(read_write_oe), .dp_in(parallel_data_bus_in), .cntl_in(control_bus_in),
        .rw_in(read_write_in));

    initial forever #25 clk_sys = ~clk_sys;
    initial begin
        #7;
        forever #15 clk_link = ~clk_link;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
        #1;
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
        @(posedge clk_sys);
    endtask

    // selects move only while the chip is cleared
    task automatic setup(input logic r, input logic i, input logic s);
        cyc(1);
        chip_clear_n <= 1'b0;
        standby_n <= 1'b1;
        cyc(4);
        role_select <= r;
        display_iface_select <= i;
        strobe_source_select <= s;
        cyc(4);
        chip_clear_n <= 1'b1;
        cyc(8);
    endtask

    task automatic summarize;
        if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_master_par;
        setup(1'b1, 1'b1, 1'b0);
        chk("is_master", 1, is_master);
        chk("device_enable", 1, device_enable);
        chk("cntl_oe", 0, control_bus_oe);
        chk("rw_oe", 0, read_write_oe);
        input_strobe0 <= 1'b1;
        host_rw <= 1'b1;
        cyc(4);
        chk("strobe0", 1, active_strobe);
        chk("rx_rw", 1, rx_rw);
        input_strobe0 <= 1'b0;
        input_strobe1 <= 1'b1;
        core_rw_state <= 1'b1;
        cyc(4);
        chk("strobe1 unused", 0, active_strobe);
        chk("dp_oe read", 18'h3ffff, parallel_data_bus_oe);
        core_rw_state <= 1'b0;
        input_strobe1 <= 1'b0;
        core_link_drive <= 1'b1;
        core_link_clk <= 1'b1;
        link_pad_in <= 4'h1;
        cyc(6);
        chk("dp_oe write", 0, parallel_data_bus_oe);
        chk("pads master", 5'h15, {link_pad_oe == 4'hf, link_pad_out});
        chk("link rx master", 2'h2, {rx_link_clk, rx_link_data});
        core_link_drive <= 1'b0;
        standby_n <= 1'b0;
        cyc(6);
        chk("standby", 0, device_enable);
        chk("wclk standby", 2'h3, {output_word_clock1, output_word_clock0});
        chk("pads off", 0, link_pad_oe);
        standby_n <= 1'b1;
        cyc(6);
        chk("wake", 1, device_enable);
    endtask

    task automatic t_master_src1;
        setup(1'b1, 1'b1, 1'b1);
        input_strobe1 <= 1'b1;
        cyc(4);
        chk("strobe1", 1, active_strobe);
        input_strobe1 <= 1'b0;
        chip_clear_n <= 1'b0;
        cyc(6);
        chk("cleared", 0, device_enable);
        chk("wclk clear", 2'h3, {output_word_clock1, output_word_clock0});
    endtask

    task automatic t_master_spi;
        setup(1'b1, 1'b0, 1'b0);
        host_cntl <= 6'h30;
        input_strobe0 <= 1'b1;
        cyc(4);
        chk("spi strobe", 1, active_strobe);
        chk("rx_cntl", 6'h30, rx_cntl);
        chk("cs idle", 1, rx_spi_cs_n);
        host_cntl <= 6'h00;
        input_strobe0 <= 1'b0;
        cyc(4);
        chk("spi strobe low", 0, active_strobe);
        chk("cs active", 0, rx_spi_cs_n);
    endtask

    task automatic t_slave_par;
        setup(1'b0, 1'b1, 1'b0);
        chk("is_master", 0, is_master);
        chk("cntl_oe", 6'h3f, control_bus_oe);
        chk("rw_oe", 1, read_write_oe);
        chk("dp_oe write", 18'h3ffff, parallel_data_bus_oe);
        core_rw_state <= 1'b1;
        edge_rate_select <= 1'b1;
        standby_n <= 1'b0;
        core_link_drive <= 1'b1;
        core_link_clk <= 1'b1;
        cyc(6);
        chk("dp_oe read", 0, parallel_data_bus_oe);
        chk("rw_out", 1, read_write_out);
        chk("fast", 1, fast_edges);
        chk("no local standby", 1, device_enable);
        chk("pads slave", 5'h1a, {link_pad_oe == 4'hf, link_pad_out});
        chk("link rx slave", 2'h1, {rx_link_clk, rx_link_data});
        edge_rate_select <= 1'b0;
        core_rw_state <= 1'b0;
        core_link_standby <= 1'b1;
        cyc(8);
        chk("slow", 0, fast_edges);
        chk("link standby", 0, device_enable);
        core_link_standby <= 1'b0;
        core_link_drive <= 1'b0;
        standby_n <= 1'b1;
    endtask

    task automatic t_slave_spi;
        setup(1'b0, 1'b0, 1'b0);
        core_spi_clk <= 1'b1;
        core_spi_data <= 1'b1;
        core_spi_cs_n <= 1'b0;
        core_rw_state <= 1'b1;
        core_dp_out <= 18'h3c031;
        cyc(2);
        chk("dp spi", 4'hf, {parallel_data_bus_out[7:6], parallel_data_bus_oe[7:6]});
        chk("cntl spi", 4'hf, {control_bus_out[5:4], control_bus_oe[5:4]});
        chk("spi cs", 0, output_word_clock0);
        chk("spi write", 0, read_write_out);
        chk("rx_dp", 18'h3c0f1, rx_dp);
        core_spi_clk <= 1'b0;
        core_spi_data <= 1'b0;
        core_spi_cs_n <= 1'b1;
        core_rw_state <= 1'b0;
        cyc(2);
        chk("spi low", 0, {parallel_data_bus_out[7:6], control_bus_out[5:4]});
        chk("spi cs off", 1, output_word_clock0);
    endtask

    initial begin
        cyc(2);
        reset <= 1'b0;
        t_master_par();
        t_master_src1();
        t_master_spi();
        t_slave_par();
        t_slave_spi();
        summarize();
    end

    // hang guard
    initial begin
        #500us;
        n_mismatch++;
        summarize();
    end
endmodule
